// ---- cseq_pkg.sv ----
/*
 * Constants and types for the CPU sequencer of the 4-bit tuning core.
 * Assumes a 250 MHz system clock and an instruction decoder outside.
 */
package cseq_pkg;

    // ------------------------------------------------------------
    // Widths and address map
    // ------------------------------------------------------------
    localparam int          PC_W          = 10;
    localparam logic [9:0]  PC_RESET      = 10'h000;
    localparam logic [9:0]  PC_LAST_VALID = 10'h3ef;
    localparam int          RAM_WORDS     = 48;
    localparam int          RAM_AW        = 6;
    localparam int          GREG_FIRST    = 8'h00;
    localparam int          GREG_LAST     = 8'h0f;
    localparam logic [5:0]  PA_DIR_ADDR   = 6'h1f;
    localparam logic [3:0]  PA_DIR_RESET  = 4'h0;

    // ------------------------------------------------------------
    // Bank flag encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  BANK_ZERO     = 2'h0;
    localparam logic [1:0]  BANK_ONE      = 2'h1;
    localparam logic [1:0]  BANK_TWO      = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ       = 250;
    localparam int          TICK_US       = 125000;
    localparam int          TICK_CYCLES   = TICK_US * CLK_MHZ;
    localparam int          CE_MIN_US     = 134;
    localparam int          CE_MIN_CYCLES = CE_MIN_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Instruction kinds from the decoder
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_PLAIN       = 4'h0,
        OP_JUMP        = 4'h1,
        OP_CALL        = 4'h2,
        OP_RET         = 4'h3,
        OP_RET_SKIP    = 4'h4,
        OP_SKIP_TEST   = 4'h5,
        OP_TICK_TEST   = 4'h6,
        OP_CLOCK_HALT  = 4'h7,
        OP_CARRY_SET   = 4'h8,
        OP_CARRY_CLEAR = 4'h9,
        OP_ARITH       = 4'ha,
        OP_ARITH_SKIP  = 4'hb,
        OP_BANK_ZERO   = 4'hc,
        OP_BANK_ONE    = 4'hd,
        OP_BANK_TWO    = 4'he,
        OP_PORT_OUT    = 4'hf
    } cseq_op_type;

    // ------------------------------------------------------------
    // Run states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN       = 4'h1,
        ST_WAIT_RUN  = 4'h2,
        ST_HALT      = 4'h4,
        ST_WAIT_HALT = 4'h8
    } cseq_state_type;

endpackage

// ---- cseq_core.sv ----
/*
 * Program sequencing, return address, tick, carry and bank flags, data
 * memory with its plain access port.
 * Assumes the decoder pulses EXEC once per instruction with its kind.
 */
// Chosen here: strobed register access and the placing of the registers.
// Overview of operation
// R1: Ten-bit binary instruction address counter
// R2: Advance by one; jump and call load operand
// R3: Skip sequences on; next instruction acts as no-op
// R4: Call saves incremented address, one entry only
// R5: Either return reloads the saved address
// R6: Valid program addresses 000h to 3efh only
// R7: Forty-eight four-bit words, lowest sixteen general registers
// R8: Word 1fh gives port A directions
// R9: Tick flag set every 125 ms, test clears
// R10: Power-on clears tick; halt or CE rise sets
// R11: No periodic set until first tick test
// R12: Reset: address zero, bank zero, ports input
// R13: CE rise waits for tick, restarts at zero
// R14: After halt, CE rise restarts after tick set
// R15: Test beats coincident set; no restart then
// R16: Tick test skips when flag was clear
// R17: Arithmetic updates carry; others leave it alone
// R18: Dedicated set and clear carry instructions
// R19: Bank instructions load 00, 01 or 10
// R20: Data memory reachable only in bank zero
// R21: Power-on and CE rise select bank zero
// R22: Halt with CE low stops processor, keeps memory
// R23: CE pulses below 134 us are ignored
// R24: Tick source is free-running clock divider
`timescale 1ns/1ps
module cseq_core #(
    parameter int TICK_CYCLES   = cseq_pkg::TICK_CYCLES,
    parameter int CE_MIN_CYCLES = cseq_pkg::CE_MIN_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic        EXEC,
    input  wire logic [3:0]  OP,
    input  wire logic [9:0]  OPERAND,
    input  wire logic        COND,
    input  wire logic        CARRY_IN,
    input  wire logic [5:0]  MEM_ADDR,
    input  wire logic [3:0]  MEM_WDATA,
    input  wire logic        MEM_WR,
    input  wire logic        MEM_RD,
    output logic      [3:0]  MEM_RDATA,
    output logic      [9:0]  PC,
    output logic             PC_INVALID,
    output logic             SKIP_NEXT,
    output logic             CARRY,
    output logic      [1:0]  BANK,
    output logic             TICK_FLAG,
    output logic             TICK_RESULT,
    output logic             HALTED,
    output logic             RESTART_WAIT,
    output logic             PORTS_INPUT,
    output logic      [3:0]  PORT_A_DIR
);

    // ------------------------------------------------------------
    // Reset release and CE input
    // ------------------------------------------------------------
    logic [1:0]  rst_sync_q;
    logic        rst_n_q;
    logic [1:0]  ce_sync_q;
    logic        ce_f_q;
    logic [15:0] ce_cnt_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_q = rst_sync_q[1];

    // CE path starts high: a pin already high at power-on is no rising edge
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ce_sync_q <= 2'h3;
        end else begin
            ce_sync_q <= {ce_sync_q[0], CE};
        end
    end

    // Filter is slow on purpose: a level must hold before anything reacts
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ce_cnt_q <= 16'h0;
            ce_f_q   <= 1'b1;
        end else if (ce_sync_q[1] == ce_f_q) begin
            ce_cnt_q <= 16'h0;
        end else if (ce_cnt_q == 16'(CE_MIN_CYCLES - 1)) begin
            ce_cnt_q <= 16'h0; // R23
            ce_f_q   <= ce_sync_q[1]; // R23
        end else begin
            ce_cnt_q <= ce_cnt_q + 16'h1;
        end
    end

    logic ce_f_prev_q;
    logic ce_rise;
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ce_f_prev_q <= 1'b1;
        end else begin
            ce_f_prev_q <= ce_f_q;
        end
    end
    assign ce_rise = ce_f_q && !ce_f_prev_q;

    // ------------------------------------------------------------
    // Tick divider
    // ------------------------------------------------------------
    logic [24:0] div_q;
    logic        set_pulse;

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= 25'h0;
        end else if (div_q == 25'(TICK_CYCLES - 1)) begin
            div_q <= 25'h0; // R24
        end else begin
            div_q <= div_q + 25'h1; // R24
        end
    end
    assign set_pulse = (div_q == 25'(TICK_CYCLES - 1));

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    cseq_pkg::cseq_state_type state_q;
    cseq_pkg::cseq_op_type    op;
    logic skip_q;
    logic tick_q;
    logic armed_q;
    logic running;
    logic waiting;
    logic act;
    logic go;
    logic tick_test;
    logic restart;
    logic halt_req;
    logic skip_hit;
    logic tick_res;

    assign op        = cseq_pkg::cseq_op_type'(OP);
    assign running   = (state_q == cseq_pkg::ST_RUN) || (state_q == cseq_pkg::ST_WAIT_RUN);
    assign waiting   = (state_q == cseq_pkg::ST_WAIT_RUN) || (state_q == cseq_pkg::ST_WAIT_HALT);
    assign tick_test = EXEC && running && !skip_q && (op == cseq_pkg::OP_TICK_TEST); // R15
    assign restart   = waiting && set_pulse && !tick_test; // R13 R14 R15
    assign go        = EXEC && running && !restart; // R22
    assign act       = go && !skip_q; // R3
    assign halt_req  = act && (op == cseq_pkg::OP_CLOCK_HALT) && !ce_f_q; // R22
    assign tick_res  = tick_q || (set_pulse && armed_q); // R15

    always_comb begin
        case (op)
            cseq_pkg::OP_RET_SKIP,
            cseq_pkg::OP_SKIP_TEST,
            cseq_pkg::OP_ARITH_SKIP: skip_hit = COND;
            cseq_pkg::OP_TICK_TEST:  skip_hit = !tick_res; // R16
            default:                 skip_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= cseq_pkg::ST_RUN;
        end else begin
            case (state_q)
                cseq_pkg::ST_RUN: begin
                    if (halt_req) begin
                        state_q <= cseq_pkg::ST_HALT; // R22
                    end else if (ce_rise) begin
                        state_q <= cseq_pkg::ST_WAIT_RUN; // R13
                    end
                end
                cseq_pkg::ST_HALT: begin
                    if (ce_rise) begin
                        state_q <= cseq_pkg::ST_WAIT_HALT; // R14
                    end
                end
                cseq_pkg::ST_WAIT_RUN,
                cseq_pkg::ST_WAIT_HALT: begin
                    if (restart) begin
                        state_q <= cseq_pkg::ST_RUN;
                    end
                end
                default: state_q <= cseq_pkg::ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program counter, return address, skip
    // ------------------------------------------------------------
    logic [9:0] pc_q;
    logic [9:0] ret_q;
    logic [9:0] pc_inc;
    assign pc_inc = pc_q + 10'h1;

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pc_q <= cseq_pkg::PC_RESET; // R12
        end else if (restart) begin
            pc_q <= cseq_pkg::PC_RESET; // R13
        end else if (go) begin
            if (act && (op == cseq_pkg::OP_JUMP || op == cseq_pkg::OP_CALL)) begin
                pc_q <= OPERAND; // R2
            end else if (act && (op == cseq_pkg::OP_RET || op == cseq_pkg::OP_RET_SKIP)) begin
                pc_q <= ret_q; // R5
            end else begin
                pc_q <= pc_inc; // R1 R2 R3
            end
        end
    end

    // One entry: a nested call overwrites the earlier return address
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ret_q <= cseq_pkg::PC_RESET;
        end else if (act && op == cseq_pkg::OP_CALL) begin
            ret_q <= pc_inc; // R4
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            skip_q <= 1'b0;
        end else if (restart) begin
            skip_q <= 1'b0;
        end else if (go) begin
            skip_q <= act && skip_hit; // R3
        end
    end

    // ------------------------------------------------------------
    // Tick flag
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            armed_q <= 1'b0;
        end else if (tick_test) begin
            armed_q <= 1'b1; // R11
        end
    end

    // Test wins over a coincident periodic set: that set is consumed
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tick_q <= 1'b0; // R10
        end else if (tick_test) begin
            tick_q <= 1'b0; // R9 R15
        end else if (restart || halt_req) begin
            tick_q <= 1'b1; // R10
        end else if (set_pulse && armed_q) begin
            tick_q <= 1'b1; // R9 R11
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            TICK_RESULT <= 1'b0;
        end else if (tick_test) begin
            TICK_RESULT <= tick_res; // R16
        end
    end

    // ------------------------------------------------------------
    // Carry, bank, port mode
    // ------------------------------------------------------------
    logic       carry_q;
    logic [1:0] bank_q;
    logic       pin_q;

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            carry_q <= 1'b0;
        end else if (act) begin
            case (op)
                cseq_pkg::OP_ARITH,
                cseq_pkg::OP_ARITH_SKIP:  carry_q <= CARRY_IN; // R17
                cseq_pkg::OP_CARRY_SET:   carry_q <= 1'b1; // R18
                cseq_pkg::OP_CARRY_CLEAR: carry_q <= 1'b0; // R18
                default:                  carry_q <= carry_q;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bank_q <= cseq_pkg::BANK_ZERO; // R12 R21
        end else if (restart) begin
            bank_q <= cseq_pkg::BANK_ZERO; // R21
        end else if (act) begin
            case (op)
                cseq_pkg::OP_BANK_ZERO: bank_q <= cseq_pkg::BANK_ZERO; // R19
                cseq_pkg::OP_BANK_ONE:  bank_q <= cseq_pkg::BANK_ONE; // R19
                cseq_pkg::OP_BANK_TWO:  bank_q <= cseq_pkg::BANK_TWO; // R19
                default:                bank_q <= bank_q;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_q <= 1'b1; // R12
        end else if (restart || halt_req) begin
            pin_q <= 1'b1; // R12
        end else if (act && op == cseq_pkg::OP_PORT_OUT) begin
            pin_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------
    logic [3:0] ram_q [cseq_pkg::RAM_WORDS];
    logic [3:0] dir_q;
    logic [3:0] rdata_q;
    logic       mem_ok;

    assign mem_ok = (bank_q == cseq_pkg::BANK_ZERO) && (MEM_ADDR < 6'(cseq_pkg::RAM_WORDS)); // R20

    // Contents survive halt and restart; only the write port changes them
    always_ff @(posedge CLK) begin
        if (MEM_WR && mem_ok) begin
            ram_q[MEM_ADDR] <= MEM_WDATA; // R7
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dir_q <= cseq_pkg::PA_DIR_RESET;
        end else if (MEM_WR && mem_ok && MEM_ADDR == cseq_pkg::PA_DIR_ADDR) begin
            dir_q <= MEM_WDATA; // R8
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 4'h0;
        end else if (MEM_RD && mem_ok) begin
            rdata_q <= ram_q[MEM_ADDR]; // R7 R20
        end else begin
            rdata_q <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign MEM_RDATA    = rdata_q;
    assign PC           = pc_q;
    assign PC_INVALID   = (pc_q > cseq_pkg::PC_LAST_VALID); // R6
    assign SKIP_NEXT    = skip_q;
    assign CARRY        = carry_q;
    assign BANK         = bank_q;
    assign TICK_FLAG    = tick_q;
    assign HALTED       = (state_q == cseq_pkg::ST_HALT) || (state_q == cseq_pkg::ST_WAIT_HALT);
    assign RESTART_WAIT = waiting;
    assign PORTS_INPUT  = pin_q;
    assign PORT_A_DIR   = pin_q ? 4'h0 : dir_q; // R8

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_PC_STEP: assert property (@(posedge CLK) disable iff (!rst_n_q) // R2
        (go && (!act || op == cseq_pkg::OP_PLAIN)) |=> pc_q == $past(pc_q) + 10'h1)
        else $error("pc did not advance by one");
    AST_JUMP: assert property (@(posedge CLK) disable iff (!rst_n_q) // R2
        (act && op == cseq_pkg::OP_JUMP) |=> pc_q == $past(OPERAND))
        else $error("jump target not loaded");
    AST_CALL_RET: assert property (@(posedge CLK) disable iff (!rst_n_q) // R4
        (act && op == cseq_pkg::OP_CALL) |=> ret_q == $past(pc_q) + 10'h1)
        else $error("return address wrong");
    AST_RETURN: assert property (@(posedge CLK) disable iff (!rst_n_q) // R5
        (act && (op == cseq_pkg::OP_RET || op == cseq_pkg::OP_RET_SKIP)) |=> pc_q == $past(ret_q))
        else $error("return did not reload address");
    AST_SKIP_NOP: assert property (@(posedge CLK) disable iff (!rst_n_q) // R3
        (go && skip_q && op == cseq_pkg::OP_CARRY_SET && !carry_q) |=> !carry_q)
        else $error("skipped instruction took effect");
    AST_TICK_TEST: assert property (@(posedge CLK) disable iff (!rst_n_q) // R15
        tick_test |=> !tick_q && TICK_RESULT == $past(tick_res))
        else $error("tick test did not clear flag");
    AST_UNARMED: assert property (@(posedge CLK) disable iff (!rst_n_q) // R11
        (!armed_q && !tick_q && !restart && !halt_req) |=> !tick_q)
        else $error("tick set before first test");
    AST_RESTART: assert property (@(posedge CLK) disable iff (!rst_n_q) // R13
        restart |=> pc_q == cseq_pkg::PC_RESET && tick_q && bank_q == cseq_pkg::BANK_ZERO)
        else $error("restart state wrong");
    AST_CARRY_KEEP: assert property (@(posedge CLK) disable iff (!rst_n_q) // R17
        (act && op == cseq_pkg::OP_JUMP) |=> $stable(carry_q))
        else $error("carry changed by non-arithmetic op");
    AST_BANK_GATE: assert property (@(posedge CLK) disable iff (!rst_n_q) // R20
        (MEM_RD && bank_q != cseq_pkg::BANK_ZERO) |=> rdata_q == 4'h0)
        else $error("memory read outside bank zero");
    AST_HALT_FROZEN: assert property (@(posedge CLK) disable iff (!rst_n_q) // R22
        (HALTED && !restart) |=> $stable(pc_q))
        else $error("pc moved while halted");

endmodule

// ---- cseq_core_tb_top.sv ----
/*
 * Self-checking bench for the CPU sequencer core: sequencing, flags, memory.
 * Assumes a 250 MHz clock and shortened tick and chip-enable filter counts.
 */
`timescale 1ns/1ps
module cseq_core_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    // Short counts keep the run small; expectations follow from TICK
    localparam int TICK = 64;
    logic       CLK;
    logic       RST_N;
    logic       CE;
    logic       EXEC;
    logic [3:0] OP;
    logic [9:0] OPERAND;
    logic       COND;
    logic       CARRY_IN;
    logic [5:0] MEM_ADDR;
    logic [3:0] MEM_WDATA;
    logic       MEM_WR;
    logic       MEM_RD;
    logic [3:0] MEM_RDATA;
    logic [9:0] PC;
    logic       PC_INVALID;
    logic       SKIP_NEXT;
    logic       CARRY;
    logic [1:0] BANK;
    logic       TICK_FLAG;
    logic       TICK_RESULT;
    logic       HALTED;
    logic       RESTART_WAIT;
    logic       PORTS_INPUT;
    logic [3:0] PORT_A_DIR;
    int         error_cnt;
    int         checks;
    int         n;

    cseq_core #(.TICK_CYCLES(TICK), .CE_MIN_CYCLES(4)) i_cseq_core (
        .CLK(CLK), .RST_N(RST_N), .CE(CE), .EXEC(EXEC), .OP(OP), .OPERAND(OPERAND),
        .COND(COND), .CARRY_IN(CARRY_IN), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
        .MEM_WR(MEM_WR), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .PC(PC),
        .PC_INVALID(PC_INVALID), .SKIP_NEXT(SKIP_NEXT), .CARRY(CARRY), .BANK(BANK),
        .TICK_FLAG(TICK_FLAG), .TICK_RESULT(TICK_RESULT), .HALTED(HALTED),
        .RESTART_WAIT(RESTART_WAIT), .PORTS_INPUT(PORTS_INPUT), .PORT_A_DIR(PORT_A_DIR)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ex(input logic [3:0] op, input logic [9:0] arg = 10'h000,
                      input logic cnd = 1'b0, input logic cin = 1'b0);
        @(posedge CLK);
        EXEC <= 1'b1;
        OP <= op;
        OPERAND <= arg;
        COND <= cnd;
        CARRY_IN <= cin;
        @(posedge CLK);
        EXEC <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the read strobe
    task automatic mem(input logic wr, input logic [5:0] a, input logic [3:0] d);
        @(posedge CLK);
        MEM_WR <= wr;
        MEM_RD <= !wr;
        MEM_ADDR <= a;
        MEM_WDATA <= d;
        @(posedge CLK);
        MEM_WR <= 1'b0;
        MEM_RD <= 1'b0;
        #1;
    endtask

    task automatic wait_flag(output int cnt);
        cnt = 0;
        while (TICK_FLAG !== 1'b1 && cnt < 300) begin
            @(posedge CLK);
            #1;
            cnt++;
        end
    endtask

    task automatic wait_restart(output int cnt);
        cnt = 0;
        while ((PC !== 10'h000 || RESTART_WAIT !== 1'b0 || HALTED !== 1'b0) && cnt < 300) begin
            @(posedge CLK);
            #1;
            cnt++;
        end
    endtask

    task automatic ce_low(input int len);
        @(posedge CLK);
        CE <= 1'b0;
        repeat (len) @(posedge CLK);
        CE <= 1'b1;
        #1;
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Whole sequence needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        RST_N = 1'b0;
        CE = 1'b1;
        EXEC = 1'b0;
        OP = 4'h0;
        OPERAND = 10'h000;
        COND = 1'b0;
        CARRY_IN = 1'b0;
        MEM_ADDR = 6'h00;
        MEM_WDATA = 4'h0;
        MEM_WR = 1'b0;
        MEM_RD = 1'b0;
        error_cnt = 0;
        checks = 0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        check(PC, 10'h000);
        check(BANK, 2'h0);
        check(PORTS_INPUT, 1'b1);
        check(TICK_FLAG, 1'b0);
        repeat (2 * TICK) @(posedge CLK);
        #1;
        check(TICK_FLAG, 1'b0);
        ex(cseq_pkg::OP_TICK_TEST);
        check(TICK_RESULT, 1'b0);
        check(SKIP_NEXT, 1'b1);
        ex(cseq_pkg::OP_CARRY_SET);
        check(CARRY, 1'b0);
        check(PC, 10'h002);
        wait_flag(n);
        check(n <= TICK + 2, 1'b1);
        ex(cseq_pkg::OP_TICK_TEST);
        check(TICK_RESULT, 1'b1);
        check(SKIP_NEXT, 1'b0);
        check(TICK_FLAG, 1'b0);
        wait_flag(n);
        check(10'(n + 2), 10'(TICK));
        ex(cseq_pkg::OP_JUMP, 10'h3ee);
        check(PC_INVALID, 1'b0);
        ex(cseq_pkg::OP_PLAIN);
        check(PC, 10'h3ef);
        check(PC_INVALID, 1'b0);
        ex(cseq_pkg::OP_PLAIN);
        check(PC_INVALID, 1'b1);
        ex(cseq_pkg::OP_JUMP, 10'h3ff);
        ex(cseq_pkg::OP_PLAIN);
        check(PC, 10'h000);
        ex(cseq_pkg::OP_JUMP, 10'h200);
        ex(cseq_pkg::OP_CALL, 10'h100);
        check(PC, 10'h100);
        ex(cseq_pkg::OP_PLAIN);
        ex(cseq_pkg::OP_RET);
        check(PC, 10'h201);
        ex(cseq_pkg::OP_CALL, 10'h155);
        ex(cseq_pkg::OP_RET_SKIP, 10'h000, 1'b1);
        check(PC, 10'h202);
        check(SKIP_NEXT, 1'b1);
        ex(cseq_pkg::OP_SKIP_TEST, 10'h000, 1'b1);
        check(SKIP_NEXT, 1'b0);
        ex(cseq_pkg::OP_CARRY_SET);
        check(CARRY, 1'b1);
        ex(cseq_pkg::OP_PLAIN);
        check(CARRY, 1'b1);
        ex(cseq_pkg::OP_ARITH);
        check(CARRY, 1'b0);
        ex(cseq_pkg::OP_ARITH_SKIP, 10'h000, 1'b0, 1'b1);
        check(CARRY, 1'b1);
        ex(cseq_pkg::OP_CARRY_CLEAR);
        check(CARRY, 1'b0);
        mem(1'b1, 6'h05, 4'h3);
        ex(cseq_pkg::OP_BANK_ONE);
        check(BANK, 2'h1);
        mem(1'b1, 6'h05, 4'ha);
        mem(1'b0, 6'h05, 4'h0);
        check(MEM_RDATA, 4'h0);
        ex(cseq_pkg::OP_BANK_TWO);
        check(BANK, 2'h2);
        ex(cseq_pkg::OP_BANK_ZERO);
        check(BANK, 2'h0);
        mem(1'b0, 6'h05, 4'h0);
        check(MEM_RDATA, 4'h3);
        mem(1'b1, 6'h2f, 4'h6);
        mem(1'b0, 6'h2f, 4'h0);
        check(MEM_RDATA, 4'h6);
        mem(1'b0, 6'h30, 4'h0);
        check(MEM_RDATA, 4'h0);
        mem(1'b1, 6'h1f, 4'h9);
        check(PORT_A_DIR, 4'h0);
        ex(cseq_pkg::OP_PORT_OUT);
        check(PORT_A_DIR, 4'h9);
        // Glitch on chip enable must leave the program running
        ex(cseq_pkg::OP_JUMP, 10'h055);
        ex(cseq_pkg::OP_BANK_ONE);
        ce_low(2);
        repeat (3 * TICK) @(posedge CLK);
        #1;
        check(PC, 10'h056);
        check(RESTART_WAIT, 1'b0);
        // Align to the tick so the wait is seen before the restart
        ex(cseq_pkg::OP_TICK_TEST);
        wait_flag(n);
        check(n <= TICK, 1'b1);
        ex(cseq_pkg::OP_TICK_TEST);
        ce_low(20);
        repeat (15) @(posedge CLK);
        #1;
        check(RESTART_WAIT, 1'b1);
        check(PC, 10'h058);
        wait_restart(n);
        check(n < TICK, 1'b1);
        check(TICK_FLAG, 1'b1);
        check(BANK, 2'h0);
        check(PORTS_INPUT, 1'b1);
        ex(cseq_pkg::OP_TICK_TEST);
        @(posedge CLK);
        CE <= 1'b0;
        repeat (20) @(posedge CLK);
        ex(cseq_pkg::OP_CLOCK_HALT);
        check(HALTED, 1'b1);
        check(TICK_FLAG, 1'b1);
        ex(cseq_pkg::OP_JUMP, 10'h123);
        check(PC, 10'h002);
        @(posedge CLK);
        CE <= 1'b1;
        wait_restart(n);
        check(n < 2 * TICK, 1'b1);
        check(TICK_FLAG, 1'b1);
        mem(1'b0, 6'h2f, 4'h0);
        check(MEM_RDATA, 4'h6);
        // Test lands on the periodic set while a restart is pending
        ex(cseq_pkg::OP_TICK_TEST);
        ce_low(20);
        repeat (37) @(posedge CLK);
        ex(cseq_pkg::OP_TICK_TEST);
        check(TICK_RESULT, 1'b1);
        check(TICK_FLAG, 1'b0);
        check(RESTART_WAIT, 1'b1);
        check(PC, 10'h002);
        wait_restart(n);
        check(10'(n), 10'(TICK));
        give_verdict();
    end
endmodule
